// File: host_port_ctrl_pkg.sv
// Constants for the host port switch control register bank
//
// Functional notes
// - Receive enable set: accept host port packets; cleared: refuse them.
// - Learning disable is bit 8, resets 0; set stops source address learning.
// - Sniffer bit 7 makes the port the mirror destination for monitored packets.
// - Receive sniff bit 6 marks received packets monitored and copies them to sniffer.
// - Transmit sniff bit 5 marks transmitted packets monitored and copies them to sniffer.
// - Ceiling bit 3 clamps packet priority above the default tag priority to it.
// - Membership bits 2-0 reset to 7; bit2 host, bit1 port 2, bit0 port 1.
// - Traffic from this port goes only to ports included in its membership; the code masks only fwd_mask, mirror copies go to all sniffer_ports.
// - Receive enable is bit 9 and resets to 1.
`default_nettype none
package host_port_ctrl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0]  IDX_CONTROL_TWO   = 4'h2;
    localparam logic [3:0]  IDX_VID_CONTROL   = 4'h4;
    localparam logic [3:0]  IDX_CONTROL_THREE = 4'h6;
    localparam logic [3:0]  IDX_INGRESS_RATE  = 4'h8;
    localparam logic [3:0]  IDX_EGRESS_RATE   = 4'ha;
    localparam logic [3:0]  IDX_BANK_SELECT   = 4'he;

    // Control two field positions
    localparam int          BIT_INGRESS_FILTER = 14;
    localparam int          BIT_DISCARD_NON_PVID = 13;
    localparam int          BIT_TX_ENABLE     = 10;
    localparam int          BIT_RX_ENABLE     = 9;
    localparam int          BIT_LEARN_DISABLE = 8;
    localparam int          BIT_SNIFFER       = 7;
    localparam int          BIT_RX_SNIFF      = 6;
    localparam int          BIT_TX_SNIFF      = 5;
    localparam int          BIT_PRIO_CEILING  = 3;
    localparam int          MEMBER_MSB        = 2;
    localparam int          MEMBER_HOST       = 2;

    // Control two writable bits and reset value
    localparam logic [15:0] CONTROL_TWO_WMASK = 16'h67ff;
    localparam logic [15:0] CONTROL_TWO_RESET = 16'h0607;

    // Default tag layout inside the VID control register
    localparam int          VID_PRIO_MSB      = 15;
    localparam int          VID_PRIO_LSB      = 13;
    localparam int          VID_ID_MSB        = 11;

    localparam logic [15:0] OTHER_RESET       = 16'h0000;
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ        = 2'h3;

endpackage

`default_nettype wire

// File: host_port_switch_control.sv
// Host port switch control registers on AHB-Lite with packet steering logic
`timescale 1ns/1ps
`default_nettype none

module host_port_switch_control #(
    parameter int PORTS  = 3,
    parameter int PRIO_W = 3,
    parameter int VID_W  = 12
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              rx_valid,
    input  wire logic [PORTS-1:0]  rx_dest_mask,
    input  wire logic [PRIO_W-1:0] rx_priority,
    input  wire logic              rx_tagged,
    input  wire logic [VID_W-1:0]  rx_vid,
    input  wire logic [PORTS-1:0]  vlan_members,
    input  wire logic [PORTS-1:0]  sniffer_ports,
    input  wire logic              tx_valid,
    output logic                   rx_accept,
    output logic                   rx_drop,
    output logic                   learn_strobe,
    output logic [PORTS-1:0]       fwd_mask,
    output logic [PORTS-1:0]       mirror_mask,
    output logic [PRIO_W-1:0]      fwd_priority,
    output logic                   fwd_monitored,
    output logic                   tx_grant,
    output logic                   tx_mirror,
    output logic [PORTS-1:0]       tx_mirror_mask,
    output logic                   host_is_sniffer,
    output logic                   learn_enabled
);

    typedef struct packed {
        logic [15:0]       control_two;
        logic [15:0]       vid_control;
        logic [15:0]       control_three;
        logic [15:0]       ingress_rate;
        logic [15:0]       egress_rate;
        logic [15:0]       bank_select;
        logic              wr_pend;
        logic [3:0]        wr_idx;
        logic              wr_hit;
        logic              hreadyout;
        logic [31:0]       hrdata;
        logic              rx_accept;
        logic              rx_drop;
        logic              learn_strobe;
        logic [PORTS-1:0]  fwd_mask;
        logic [PORTS-1:0]  mirror_mask;
        logic [PRIO_W-1:0] fwd_priority;
        logic              fwd_monitored;
        logic              tx_grant;
        logic              tx_mirror;
        logic [PORTS-1:0]  tx_mirror_mask;
        logic              host_is_sniffer;
        logic              learn_enabled;
    } state_t;

    state_t st;
    state_t next_st;

    logic              addr_phase;
    logic [3:0]        addr_idx;
    logic              addr_hit;
    logic [PRIO_W-1:0] default_prio;
    logic [VID_W-1:0]  default_vid;
    logic [PORTS-1:0]  membership;
    logic              vid_mismatch;
    logic              filter_miss;
    logic              rx_ok;

    // Reads and the sniffer and learning status outputs see the register values after any write landing this cycle
    function automatic logic [15:0] reg_value(input state_t s, input logic [3:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        unique case (idx)
            host_port_ctrl_pkg::IDX_CONTROL_TWO:   v = s.control_two;
            host_port_ctrl_pkg::IDX_VID_CONTROL:   v = s.vid_control;
            host_port_ctrl_pkg::IDX_CONTROL_THREE: v = s.control_three;
            host_port_ctrl_pkg::IDX_INGRESS_RATE:  v = s.ingress_rate;
            host_port_ctrl_pkg::IDX_EGRESS_RATE:   v = s.egress_rate;
            host_port_ctrl_pkg::IDX_BANK_SELECT:   v = s.bank_select;
            default:                               v = 16'h0000;
        endcase
        return v;
    endfunction

    function automatic logic idx_mapped(input logic [3:0] idx);
        logic m;
        m = (idx == host_port_ctrl_pkg::IDX_CONTROL_TWO) ||
            (idx == host_port_ctrl_pkg::IDX_VID_CONTROL) ||
            (idx == host_port_ctrl_pkg::IDX_CONTROL_THREE) ||
            (idx == host_port_ctrl_pkg::IDX_INGRESS_RATE) ||
            (idx == host_port_ctrl_pkg::IDX_EGRESS_RATE) ||
            (idx == host_port_ctrl_pkg::IDX_BANK_SELECT);
        return m;
    endfunction

    assign addr_phase = hsel && hready && (htrans == host_port_ctrl_pkg::HTRANS_NONSEQ ||
                                           htrans == host_port_ctrl_pkg::HTRANS_SEQ);
    assign addr_idx   = haddr[5:2];
    // Upper address bits and byte offset must be zero, else the access is unmapped
    assign addr_hit   = idx_mapped(addr_idx) && (haddr[7:6] == 2'h0) && (haddr[1:0] == 2'h0);

    always_comb begin
        next_st = st;

        // Bus slave never stalls and always answers OKAY
        next_st.hreadyout = 1'b1;

        // Data phase of a write lands here
        if (st.wr_pend && st.wr_hit) begin
            unique case (st.wr_idx)
                host_port_ctrl_pkg::IDX_CONTROL_TWO: begin
                    next_st.control_two = hwdata[15:0] & host_port_ctrl_pkg::CONTROL_TWO_WMASK;
                end
                host_port_ctrl_pkg::IDX_VID_CONTROL: begin
                    next_st.vid_control = hwdata[15:0];
                end
                host_port_ctrl_pkg::IDX_CONTROL_THREE: begin
                    next_st.control_three = hwdata[15:0];
                end
                host_port_ctrl_pkg::IDX_INGRESS_RATE: begin
                    next_st.ingress_rate = hwdata[15:0];
                end
                host_port_ctrl_pkg::IDX_EGRESS_RATE: begin
                    next_st.egress_rate = hwdata[15:0];
                end
                host_port_ctrl_pkg::IDX_BANK_SELECT: begin
                    next_st.bank_select = hwdata[15:0];
                end
                default: begin
                    next_st.bank_select = st.bank_select;
                end
            endcase
        end

        // Address phase: record writes, prepare read data from post-write values
        next_st.wr_pend = addr_phase && hwrite;
        next_st.wr_idx  = addr_idx;
        next_st.wr_hit  = addr_hit;
        if (addr_phase && !hwrite) begin
            next_st.hrdata = {16'h0000, addr_hit ? reg_value(next_st, addr_idx) : 16'h0000};
        end
    end

    // Packet steering uses the settled register values
    assign default_prio = st.vid_control[host_port_ctrl_pkg::VID_PRIO_MSB -: PRIO_W];
    assign default_vid  = st.vid_control[host_port_ctrl_pkg::VID_ID_MSB -: VID_W];
    assign membership   = st.control_two[host_port_ctrl_pkg::MEMBER_MSB -: PORTS];
    assign vid_mismatch = st.control_two[host_port_ctrl_pkg::BIT_DISCARD_NON_PVID] && rx_tagged &&
                          (rx_vid != default_vid);
    assign filter_miss  = st.control_two[host_port_ctrl_pkg::BIT_INGRESS_FILTER] &&
                          !vlan_members[host_port_ctrl_pkg::MEMBER_HOST];
    assign rx_ok        = st.control_two[host_port_ctrl_pkg::BIT_RX_ENABLE] && !vid_mismatch && !filter_miss;

    state_t pkt_st;

    always_comb begin
        pkt_st = next_st;

        // Accept or refuse a host port packet, one-cycle answer
        pkt_st.rx_accept    = rx_valid && rx_ok;
        pkt_st.rx_drop      = rx_valid && !rx_ok;
        pkt_st.learn_strobe = rx_valid && rx_ok && !st.control_two[host_port_ctrl_pkg::BIT_LEARN_DISABLE];

        if (rx_valid && rx_ok) begin
            // Lookup result never escapes the membership set
            pkt_st.fwd_mask = rx_dest_mask & membership;
            // Mirror copy is a separate mask so normal forwarding stays as is
            pkt_st.mirror_mask = st.control_two[host_port_ctrl_pkg::BIT_RX_SNIFF] ?
                                 sniffer_ports : {PORTS{1'b0}};
            pkt_st.fwd_monitored = st.control_two[host_port_ctrl_pkg::BIT_RX_SNIFF];
            if (st.control_two[host_port_ctrl_pkg::BIT_PRIO_CEILING] && rx_priority > default_prio) begin
                pkt_st.fwd_priority = default_prio;
            end else begin
                pkt_st.fwd_priority = rx_priority;
            end
        end else begin
            pkt_st.fwd_mask      = {PORTS{1'b0}};
            pkt_st.mirror_mask   = {PORTS{1'b0}};
            pkt_st.fwd_monitored = 1'b0;
            pkt_st.fwd_priority  = {PRIO_W{1'b0}};
        end

        // Transmit side: grant only while transmit is enabled
        pkt_st.tx_grant       = tx_valid && st.control_two[host_port_ctrl_pkg::BIT_TX_ENABLE];
        pkt_st.tx_mirror      = tx_valid && st.control_two[host_port_ctrl_pkg::BIT_TX_ENABLE] &&
                                st.control_two[host_port_ctrl_pkg::BIT_TX_SNIFF];
        pkt_st.tx_mirror_mask = (tx_valid && st.control_two[host_port_ctrl_pkg::BIT_TX_ENABLE] &&
                                 st.control_two[host_port_ctrl_pkg::BIT_TX_SNIFF]) ?
                                sniffer_ports : {PORTS{1'b0}};

        pkt_st.host_is_sniffer = next_st.control_two[host_port_ctrl_pkg::BIT_SNIFFER];
        pkt_st.learn_enabled   = !next_st.control_two[host_port_ctrl_pkg::BIT_LEARN_DISABLE];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st.control_two     <= host_port_ctrl_pkg::CONTROL_TWO_RESET;
            st.vid_control     <= host_port_ctrl_pkg::OTHER_RESET;
            st.control_three   <= host_port_ctrl_pkg::OTHER_RESET;
            st.ingress_rate    <= host_port_ctrl_pkg::OTHER_RESET;
            st.egress_rate     <= host_port_ctrl_pkg::OTHER_RESET;
            st.bank_select     <= host_port_ctrl_pkg::OTHER_RESET;
            st.wr_pend         <= 1'b0;
            st.wr_idx          <= 4'h0;
            st.wr_hit          <= 1'b0;
            st.hreadyout       <= 1'b1;
            st.hrdata          <= 32'h0000_0000;
            st.rx_accept       <= 1'b0;
            st.rx_drop         <= 1'b0;
            st.learn_strobe    <= 1'b0;
            st.fwd_mask        <= '0;
            st.mirror_mask     <= '0;
            st.fwd_priority    <= '0;
            st.fwd_monitored   <= 1'b0;
            st.tx_grant        <= 1'b0;
            st.tx_mirror       <= 1'b0;
            st.tx_mirror_mask  <= '0;
            st.host_is_sniffer <= 1'b0;
            st.learn_enabled   <= 1'b1;
        end else begin
            st <= pkt_st;
        end
    end

    assign hreadyout       = st.hreadyout;
    assign hresp           = 1'b0;
    assign hrdata          = st.hrdata;
    assign rx_accept       = st.rx_accept;
    assign rx_drop         = st.rx_drop;
    assign learn_strobe    = st.learn_strobe;
    assign fwd_mask        = st.fwd_mask;
    assign mirror_mask     = st.mirror_mask;
    assign fwd_priority    = st.fwd_priority;
    assign fwd_monitored   = st.fwd_monitored;
    assign tx_grant        = st.tx_grant;
    assign tx_mirror       = st.tx_mirror;
    assign tx_mirror_mask  = st.tx_mirror_mask;
    assign host_is_sniffer = st.host_is_sniffer;
    assign learn_enabled   = st.learn_enabled;

endmodule

`default_nettype wire

// File: host_port_switch_control_props.sv
// Concurrent checks on the host port switch control ports
`timescale 1ns/1ps
`default_nettype none
module host_port_switch_control_props #(
    parameter int PORTS  = 3,
    parameter int PRIO_W = 3,
    parameter int VID_W  = 12
) (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              rx_valid,
    input wire logic [PORTS-1:0]  rx_dest_mask,
    input wire logic [PRIO_W-1:0] rx_priority,
    input wire logic [PORTS-1:0]  sniffer_ports,
    input wire logic              rx_accept,
    input wire logic              rx_drop,
    input wire logic              learn_strobe,
    input wire logic [PORTS-1:0]  fwd_mask,
    input wire logic [PORTS-1:0]  mirror_mask,
    input wire logic [PRIO_W-1:0] fwd_priority,
    input wire logic              fwd_monitored,
    input wire logic              tx_grant,
    input wire logic              tx_mirror,
    input wire logic [PORTS-1:0]  tx_mirror_mask,
    input wire logic              learn_enabled
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_answer; rx_valid |=> (rx_accept ^ rx_drop); endproperty
    a_answer: assert property (p_answer) else $error("packet not answered once");
    property p_idle; !rx_valid |=> !rx_accept && !rx_drop && fwd_mask == '0; endproperty
    a_idle: assert property (p_idle) else $error("answer without packet");
    property p_drop; rx_drop |-> fwd_mask == '0 && mirror_mask == '0 && !learn_strobe; endproperty
    a_drop: assert property (p_drop) else $error("refused packet forwarded");
    property p_member; rx_accept |-> (fwd_mask & ~$past(rx_dest_mask)) == '0; endproperty
    a_member: assert property (p_member) else $error("forward outside lookup");
    // Strobe follows the setting in force when the packet was sampled, one edge behind the status level
    property p_learn; rx_accept |-> learn_strobe == $past(learn_enabled); endproperty
    a_learn: assert property (p_learn) else $error("learning strobe wrong");
    property p_mirror; mirror_mask != '0 |-> fwd_monitored && mirror_mask == $past(sniffer_ports); endproperty
    a_mirror: assert property (p_mirror) else $error("receive copy wrong");
    property p_monitor; fwd_monitored |-> rx_accept; endproperty
    a_monitor: assert property (p_monitor) else $error("monitored without accept");
    property p_tx; tx_mirror |-> tx_grant && tx_mirror_mask == $past(sniffer_ports); endproperty
    a_tx: assert property (p_tx) else $error("transmit copy wrong");
    property p_prio; rx_accept |-> fwd_priority <= $past(rx_priority); endproperty
    a_prio: assert property (p_prio) else $error("priority raised");
    c_mirror: cover property (rx_accept && mirror_mask != '0);
    c_drop: cover property (rx_drop);
    c_tx: cover property (tx_mirror);
endmodule
bind host_port_switch_control host_port_switch_control_props #(.PORTS(PORTS), .PRIO_W(PRIO_W), .VID_W(VID_W))
    i_host_port_switch_control_props (.hclk, .hresetn, .rx_valid, .rx_dest_mask, .rx_priority, .sniffer_ports,
    .rx_accept, .rx_drop, .learn_strobe, .fwd_mask, .mirror_mask, .fwd_priority, .fwd_monitored, .tx_grant,
    .tx_mirror, .tx_mirror_mask, .learn_enabled);
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the host port switch control bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] A_CTL = {2'h0, host_port_ctrl_pkg::IDX_CONTROL_TWO, 2'h0};
    localparam logic [7:0] A_VID = {2'h0, host_port_ctrl_pkg::IDX_VID_CONTROL, 2'h0};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        rx_valid = 1'b0;
    logic        rx_tagged = 1'b0;
    logic        tx_valid = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [7:0]  haddr = 8'h00;
    logic [31:0] hwdata = 32'h0;
    logic [2:0]  rx_dest_mask = 3'h0;
    logic [2:0]  rx_priority = 3'h0;
    logic [2:0]  vlan_members = 3'h0;
    logic [2:0]  sniffer_ports = 3'h0;
    logic [11:0] rx_vid = 12'h000;
    logic        hreadyout, hresp, rx_accept, rx_drop, learn_strobe, fwd_monitored;
    logic        tx_grant, tx_mirror, host_is_sniffer, learn_enabled;
    logic [2:0]  fwd_mask, mirror_mask, fwd_priority, tx_mirror_mask;
    logic [31:0] hrdata, rd;
    logic [15:0] c, v;
    logic [3:0]  idx [5] = '{4'h4, 4'h6, 4'h8, 4'ha, 4'he};
    int          errors = 0;
    int          num_checks = 0;

    host_port_switch_control i_host_port_switch_control (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_valid, .rx_dest_mask,
        .rx_priority, .rx_tagged, .rx_vid, .vlan_members, .sniffer_ports, .tx_valid, .rx_accept, .rx_drop,
        .learn_strobe, .fwd_mask, .mirror_mask, .fwd_priority, .fwd_monitored, .tx_grant, .tx_mirror,
        .tx_mirror_mask, .host_is_sniffer, .learn_enabled);

    initial forever #50 hclk = ~hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after a rising edge; hready is the slave's own hreadyout
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= host_port_ctrl_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic exp_accept(logic [15:0] c, logic [15:0] v, logic tg, logic [11:0] vid, logic [2:0] m);
        return c[9] && !(c[13] && tg && vid != v[11:0]) && !(c[14] && !m[2]);
    endfunction

    task automatic pkt(input logic [15:0] c, input logic [15:0] v);
        logic [2:0]  dest, pr, mem, sn, pe;
        logic [11:0] vid;
        logic        tg, acc;
        dest = 3'($urandom_range(7));
        pr = 3'($urandom_range(7));
        mem = 3'($urandom_range(7));
        sn = 3'($urandom_range(7));
        tg = 1'($urandom_range(1));
        // Half the packets carry the default VID so the discard path is not always taken
        vid = $urandom_range(1) ? v[11:0] : 12'($urandom_range(4095));
        acc = exp_accept(c, v, tg, vid, mem);
        pe = (c[3] && pr > v[15:13]) ? v[15:13] : pr;
        rx_valid <= 1'b1;
        tx_valid <= 1'b1;
        rx_dest_mask <= dest;
        rx_priority <= pr;
        vlan_members <= mem;
        sniffer_ports <= sn;
        rx_tagged <= tg;
        rx_vid <= vid;
        @(posedge hclk);
        rx_valid <= 1'b0;
        tx_valid <= 1'b0;
        @(posedge hclk);
        chk(rx_accept, acc);
        chk(rx_drop, !acc);
        chk(tx_grant, c[10]);
        chk(fwd_mask, acc ? dest & c[2:0] : 3'h0);
        chk(mirror_mask, (acc && c[6]) ? sn : 3'h0);
        chk(fwd_monitored, acc && c[6]);
        chk(fwd_priority, acc ? pe : 3'h0);
        chk(learn_strobe, acc && !c[8]);
        chk(tx_mirror, c[10] && c[5]);
        chk(tx_mirror_mask, (c[10] && c[5]) ? sn : 3'h0);
        chk(host_is_sniffer, c[7]);
        chk(learn_enabled, !c[8]);
    endtask

    task automatic end_sim;
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        errors++;
        end_sim();
    end

    initial begin
        void'($urandom(49083));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b1, A_CTL, 32'hffffffff);
        bus(1'b0, A_CTL, 32'h0);
        chk(rd, {16'h0, host_port_ctrl_pkg::CONTROL_TWO_WMASK});
        chk(hresp, 1'b0);
        chk(hreadyout, 1'b1);
        chk(host_is_sniffer, 1'b1);
        chk(learn_enabled, 1'b0);
        // Reset in mid-run must bring back the power-up settings
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, A_CTL, 32'h0);
        chk(rd, 32'h00000607);
        chk(learn_enabled, 1'b1);
        chk(host_is_sniffer, 1'b0);
        for (int i = 0; i < 5; i++) begin
            v = 16'($urandom_range(65535));
            bus(1'b1, {2'h0, idx[i], 2'h0}, {16'hffff, v});
            bus(1'b0, {2'h0, idx[i], 2'h0}, 32'h0);
            chk(rd, {16'h0, v});
        end
        bus(1'b1, 8'h3c, 32'hffffffff);
        bus(1'b0, 8'h3c, 32'h0);
        chk(rd, 32'h0);
        // Unmapped write must leave the last mapped register untouched
        bus(1'b0, {2'h0, idx[4], 2'h0}, 32'h0);
        chk(rd, {16'h0, v});
        for (int i = 0; i < 60; i++) begin
            c = (i == 0) ? host_port_ctrl_pkg::CONTROL_TWO_RESET : 16'($urandom_range(65535));
            c = c & host_port_ctrl_pkg::CONTROL_TWO_WMASK;
            v = 16'($urandom_range(65535));
            bus(1'b1, A_CTL, {16'h0, c});
            bus(1'b1, A_VID, {16'h0, v});
            pkt(c, v);
        end
        end_sim();
    end
endmodule
`default_nettype wire
